//--- src/dig_capture_params.svh
// Constants for the digital input edge and event capture block.
// Assumes inclusion by bare name from the package and the design files.
// Overview of operation
// R1 - Input-level read returns the present state of all 32 lines, line 0 in bit 0.
// R2 - One sticky rising-edge flag per line, set on low-to-high, held until cleared.
// R3 - A separate sticky falling-edge flag per line, set on high-to-low.
// R4 - A read through the keep address returns the flags and leaves them unchanged.
// R5 - A read through the clear address returns the flags, then zeroes the register.
// R6 - FIFO status shows stored entries 0 to 511 in bits 8:0, full in bit 16.
// R7 - Event register holds one sticky flag per source, keep and clear addresses alike.
// R8 - Event bit 0 external input; bits 1 to 3 fieldbus, second and first CAN.
// R9 - Inputs synchronised, edges from consecutive samples; a same-cycle set survives clearing.
`ifndef DIG_CAPTURE_PARAMS_SVH
`define DIG_CAPTURE_PARAMS_SVH

`define DIG_ADDR_W          8
`define DIG_DATA_W          32
`define DIG_LINES           32

// Register offsets as seen by the co-processor
`define OFS_INPUT_LEVELS    8'hd0
`define OFS_RISE_CLEAR      8'he0
`define OFS_FALL_CLEAR      8'he2
`define OFS_RISE_KEEP       8'he4
`define OFS_FALL_KEEP       8'he6
`define OFS_FIFO_STATUS     8'he8
`define OFS_EVENT_CLEAR     8'hfc
`define OFS_EVENT_KEEP      8'hfe

// Edge FIFO geometry and status fields
`define FIFO_AW             9
`define FIFO_CAPACITY       9'h1ff
`define FIFO_COUNT_LSB      0
`define FIFO_FULL_BIT       16

// Event register fields
`define EVENTS_W            4
`define EVT_EXT_BIT         0
`define EVT_FIELDBUS_BIT    1
`define EVT_CAN2_BIT        2
`define EVT_CAN1_BIT        3

// Cycles after reset before edge detection trusts its samples
`define WARMUP_CYCLES       2'h2

`endif

//--- src/dig_capture_pkg.sv
// Types shared by the capture block and its edge FIFO memory.
// Assumes the constants header sits beside it.
`include "dig_capture_params.svh"

package dig_capture_pkg;
    typedef logic [`DIG_ADDR_W-1:0] reg_addr_t;
    typedef logic [`DIG_DATA_W-1:0] word_t;
    typedef logic [`FIFO_AW-1:0]    fifo_ptr_t;
endpackage : dig_capture_pkg

//--- src/edge_fifo_mem.sv
// Storage array for the edge FIFO, one write and one read port.
// Assumes the controller keeps pointers in range; read data is registered.
`timescale 1ns/1ns
`default_nettype none
`include "dig_capture_params.svh"

module edge_fifo_mem (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wr_en_i,
    input  wire dig_capture_pkg::fifo_ptr_t wr_addr_i,
    input  wire dig_capture_pkg::word_t wr_data_i,
    input  wire dig_capture_pkg::fifo_ptr_t rd_addr_i,
    output var  dig_capture_pkg::word_t rd_data_o
);
    dig_capture_pkg::word_t mem [0:(1<<`FIFO_AW)-1];
    dig_capture_pkg::word_t rd_data_ff;
    wire                    bypass;

    // Forward a write to the same slot so a fresh head is never stale
    assign bypass = wr_en_i && (wr_addr_i == rd_addr_i);

    // Array write, no reset so it maps onto block memory
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read with forwarding
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= bypass ? wr_data_i : mem[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_ff;
endmodule : edge_fifo_mem
`default_nettype wire

//--- src/dig_edge_capture.sv
// Capture logic for 32 digital inputs: live levels, sticky edge and event flags,
// and an edge FIFO whose status the co-processor reads.
// Assumes a single read port driven in the clock domain; inputs synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "dig_capture_params.svh"

module dig_edge_capture (
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       RESET_N_I,
    input  wire logic [`DIG_LINES-1:0]      INPUT_LINES_I,
    input  wire logic                       EVENT_EXT_I,
    input  wire logic                       EVENT_FIELDBUS_I,
    input  wire logic                       EVENT_CAN2_I,
    input  wire logic                       EVENT_CAN1_I,
    input  wire logic                       RD_I,
    input  wire dig_capture_pkg::reg_addr_t ADDR_I,
    output var  dig_capture_pkg::word_t     RDATA_O,
    output logic                            RVALID_O,
    input  wire logic                       EDGE_FIFO_POP_I,
    output logic                            EDGE_FIFO_VALID_O,
    output var  dig_capture_pkg::word_t     EDGE_FIFO_DATA_O
);
    // Input synchroniser and edge history
    logic [`DIG_LINES-1:0]   in_meta_ff;
    logic [`DIG_LINES-1:0]   in_sync_ff;
    logic [`DIG_LINES-1:0]   in_prev_ff;
    logic [1:0]              warm_ff;
    wire                     warm;
    wire  [`DIG_LINES-1:0]   rise_det;
    wire  [`DIG_LINES-1:0]   fall_det;
    wire                     edge_any;

    // Sticky flags
    logic [`DIG_LINES-1:0]   rise_flags_ff;
    logic [`DIG_LINES-1:0]   fall_flags_ff;
    logic [`EVENTS_W-1:0]    event_flags_ff;
    wire  [`EVENTS_W-1:0]    event_set;
    wire  [`DIG_LINES-1:0]   nxt_rise_flags;
    wire  [`DIG_LINES-1:0]   nxt_fall_flags;
    wire  [`EVENTS_W-1:0]    nxt_event_flags;

    // Read decode
    wire                     sel_levels;
    wire                     sel_rise_clr;
    wire                     sel_fall_clr;
    wire                     sel_rise_keep;
    wire                     sel_fall_keep;
    wire                     sel_fifo;
    wire                     sel_evt_clr;
    wire                     sel_evt_keep;
    dig_capture_pkg::word_t  fifo_status;
    dig_capture_pkg::word_t  nxt_rdata;
    dig_capture_pkg::word_t  rdata_ff;
    logic                    rvalid_ff;

    // Edge FIFO control
    dig_capture_pkg::fifo_ptr_t wr_ptr_ff;
    dig_capture_pkg::fifo_ptr_t rd_ptr_ff;
    dig_capture_pkg::fifo_ptr_t count_ff;
    dig_capture_pkg::fifo_ptr_t nxt_rd_ptr;
    dig_capture_pkg::fifo_ptr_t nxt_count;
    wire                     fifo_full;
    wire                     fifo_empty;
    wire                     push;
    wire                     pop;

    // R9 two-stage synchroniser
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            in_meta_ff <= '0;
            in_sync_ff <= '0;
            in_prev_ff <= '0;
        end else begin
            in_meta_ff <= INPUT_LINES_I;
            in_sync_ff <= in_meta_ff;
            in_prev_ff <= in_sync_ff;
        end
    end

    // Hold off edge detection until the sync stage holds a real sample; the previous stage still holds its reset zero
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            warm_ff <= 2'h0;
        end else if (warm_ff != `WARMUP_CYCLES) begin
            warm_ff <= warm_ff + 2'h1;
        end
    end

    assign warm = (warm_ff == `WARMUP_CYCLES);

    // R9 edges from consecutive samples
    assign rise_det = warm ? (in_sync_ff & ~in_prev_ff) : '0;
    assign fall_det = warm ? (~in_sync_ff & in_prev_ff) : '0;
    assign edge_any = |(rise_det | fall_det);

    // R8 event source mapping, sources taken as active-high requests
    assign event_set[`EVT_EXT_BIT]      = EVENT_EXT_I;
    assign event_set[`EVT_FIELDBUS_BIT] = EVENT_FIELDBUS_I;
    assign event_set[`EVT_CAN2_BIT]     = EVENT_CAN2_I;
    assign event_set[`EVT_CAN1_BIT]     = EVENT_CAN1_I;

    // Address decode
    assign sel_levels    = RD_I && (ADDR_I == `OFS_INPUT_LEVELS);
    assign sel_rise_clr  = RD_I && (ADDR_I == `OFS_RISE_CLEAR);
    assign sel_fall_clr  = RD_I && (ADDR_I == `OFS_FALL_CLEAR);
    assign sel_rise_keep = RD_I && (ADDR_I == `OFS_RISE_KEEP);
    assign sel_fall_keep = RD_I && (ADDR_I == `OFS_FALL_KEEP);
    assign sel_fifo      = RD_I && (ADDR_I == `OFS_FIFO_STATUS);
    assign sel_evt_clr   = RD_I && (ADDR_I == `OFS_EVENT_CLEAR);
    assign sel_evt_keep  = RD_I && (ADDR_I == `OFS_EVENT_KEEP);

    // R4 keep reads leave flags alone; R5 clear reads zero them
    // R9 new edges are ORed after the clear, so the set wins
    assign nxt_rise_flags  = (sel_rise_clr ? '0 : rise_flags_ff) | rise_det;
    assign nxt_fall_flags  = (sel_fall_clr ? '0 : fall_flags_ff) | fall_det;
    // R7 event flags share the keep and clear pair
    assign nxt_event_flags = (sel_evt_clr ? '0 : event_flags_ff) | event_set;

    // R2 R3 R7 sticky flag registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            rise_flags_ff  <= '0;
            fall_flags_ff  <= '0;
            event_flags_ff <= '0;
        end else begin
            rise_flags_ff  <= nxt_rise_flags;
            fall_flags_ff  <= nxt_fall_flags;
            event_flags_ff <= nxt_event_flags;
        end
    end

    // R6 status word, unused bits read zero
    always_comb begin
        fifo_status                                        = '0;
        fifo_status[`FIFO_COUNT_LSB +: `FIFO_AW]           = count_ff;
        fifo_status[`FIFO_FULL_BIT]                        = fifo_full;
    end

    // R1 R4 R5 read data select; unmapped offsets answer zero
    assign nxt_rdata =
        sel_levels                     ? in_sync_ff :
        (sel_rise_clr | sel_rise_keep) ? rise_flags_ff :
        (sel_fall_clr | sel_fall_keep) ? fall_flags_ff :
        sel_fifo                       ? fifo_status :
        (sel_evt_clr | sel_evt_keep)   ? {{(`DIG_DATA_W-`EVENTS_W){1'b0}}, event_flags_ff} :
                                         '0;

    // Read answer one cycle after the request
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= RD_I ? nxt_rdata : rdata_ff;
            rvalid_ff <= RD_I;
        end
    end

    assign RDATA_O  = rdata_ff;
    assign RVALID_O = rvalid_ff;

    // Edge FIFO: a level snapshot is stored on any edge; overflow is dropped
    assign fifo_full  = (count_ff == `FIFO_CAPACITY);
    assign fifo_empty = (count_ff == '0);
    assign push       = edge_any && !fifo_full;
    assign pop        = EDGE_FIFO_POP_I && !fifo_empty;
    assign nxt_rd_ptr = rd_ptr_ff + {{(`FIFO_AW-1){1'b0}}, pop};
    assign nxt_count  = count_ff + {{(`FIFO_AW-1){1'b0}}, push}
                                 - {{(`FIFO_AW-1){1'b0}}, pop};

    // R6 pointers and fill count
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + {{(`FIFO_AW-1){1'b0}}, push};
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    // Head word is read ahead so it is ready when the count goes non-zero
    edge_fifo_mem u_mem (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RESET_N_I),
        .wr_en_i   (push),
        .wr_addr_i (wr_ptr_ff),
        .wr_data_i (in_sync_ff),
        .rd_addr_i (nxt_rd_ptr),
        .rd_data_o (EDGE_FIFO_DATA_O)
    );

    assign EDGE_FIFO_VALID_O = !fifo_empty;

    // Checks on the block's own behaviour
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESET_N_I);

    logic [1:0] ast_warm_ff;
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            ast_warm_ff <= 2'h0;
        end else if (ast_warm_ff != 2'h3) begin
            ast_warm_ff <= ast_warm_ff + 2'h1;
        end
    end

    // R1 level read returns synchronised inputs
    levels_read_a: assert property ( // R1
        sel_levels |=> RVALID_O && (RDATA_O == $past(in_sync_ff)))
        else $error("Level read returned wrong data");

    // R2 rising edge sets its flag
    rise_set_a: assert property ( // R2
        (ast_warm_ff == 2'h3) && in_sync_ff[0] && !in_prev_ff[0] |=> rise_flags_ff[0])
        else $error("Rising edge on line 0 not flagged");

    // R3 falling edge sets its flag
    fall_set_a: assert property ( // R3
        (ast_warm_ff == 2'h3) && !in_sync_ff[31] && in_prev_ff[31] |=> fall_flags_ff[31])
        else $error("Falling edge on line 31 not flagged");

    // R4 keep read preserves flags
    keep_read_a: assert property ( // R4
        sel_fall_keep && (fall_det == '0)
            |=> (fall_flags_ff == $past(fall_flags_ff)) && (RDATA_O == fall_flags_ff))
        else $error("Keep read changed the flags");

    // R5 clear read returns old flags then zeroes
    clear_read_a: assert property ( // R5
        sel_rise_clr |=> (RDATA_O == $past(rise_flags_ff))
            && (rise_flags_ff == $past(rise_det)))
        else $error("Clear read did not return and zero the flags");

    // R6 status word layout
    fifo_status_a: assert property ( // R6
        sel_fifo |=> (RDATA_O[8:0] == $past(count_ff))
            && (RDATA_O[16] == ($past(count_ff) == 9'h1ff))
            && (RDATA_O[31:17] == 15'h0) && (RDATA_O[15:9] == 7'h0))
        else $error("FIFO status word malformed");

    // R7 event flag stays until a clear read
    // A clear read one cycle later is the only way out
    event_sticky_a: assert property ( // R7
        event_flags_ff[0] && !sel_evt_clr |=> event_flags_ff[0]
            ##1 (event_flags_ff[0] || $past(sel_evt_clr)))
        else $error("Event flag dropped without a clear read");

    // R8 first CAN channel lands in bit 3
    event_map_a: assert property ( // R8
        EVENT_CAN1_I && !EVENT_EXT_I && !sel_evt_clr && (event_flags_ff[0] == 1'b0)
            |=> event_flags_ff[3] && !event_flags_ff[0])
        else $error("CAN event mapped to the wrong bit");

    // R9 two-cycle synchroniser and set winning over clear
    sync_delay_a: assert property ( // R9
        (ast_warm_ff == 2'h3) |-> in_sync_ff == $past(INPUT_LINES_I, 2))
        else $error("Synchroniser delay is not two cycles");

    set_wins_a: assert property ( // R9
        sel_evt_clr && EVENT_EXT_I |=> event_flags_ff[0])
        else $error("Event lost during a clearing read");

    // R4 keep read of rising flags
    rise_keep_a: assert property ( // R4
        sel_rise_keep && (rise_det == '0)
            |=> (rise_flags_ff == $past(rise_flags_ff)) && (RDATA_O == rise_flags_ff))
        else $error("Keep read changed the rising flags");

    // R5 clear read of falling flags
    fall_clear_a: assert property ( // R5
        sel_fall_clr |=> (RDATA_O == $past(fall_flags_ff))
            && (fall_flags_ff == $past(fall_det)))
        else $error("Clear read did not return and zero the falling flags");

    // R7 clear read of event flags
    event_clear_a: assert property ( // R7
        sel_evt_clr |=> (RDATA_O == {28'h0, $past(event_flags_ff)})
            && (event_flags_ff == $past(event_set)))
        else $error("Clear read did not return and zero the event flags");

    // R6 full FIFO drops pushes
    fifo_refuse_a: assert property ( // R6
        fifo_full && !pop |=> fifo_full)
        else $error("Full FIFO changed without a pop");

    // R6 count follows pushes
    fifo_push_a: assert property ( // R6
        push && !pop |=> count_ff == $past(count_ff) + 9'h1)
        else $error("FIFO count missed a push");

    // R6 count follows pops
    fifo_pop_a: assert property ( // R6
        pop && !push |=> count_ff == $past(count_ff) - 9'h1)
        else $error("FIFO count missed a pop");

    clear_with_edge_c: cover property (sel_rise_clr && (rise_det != '0));
    fifo_full_c:       cover property (fifo_full && pop);
    event_read_c:      cover property (sel_evt_keep ##1 sel_evt_clr);
    level_read_c:      cover property (sel_levels && (in_sync_ff != '0));
    event_clear_c:     cover property (sel_evt_clr && EVENT_EXT_I);
endmodule : dig_edge_capture
`default_nettype wire

//--- verification/sig_source.sv
// Model of the external signal sources that feed the capture block.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ns
`default_nettype none

module sig_source (
    input  wire logic        clk_i,
    output logic [31:0]      lines_o,
    output logic [3:0]       events_o
);
    // Quiet sources until the bench asks for activity
    initial begin
        lines_o  = 32'h0;
        events_o = 4'h0;
    end

    // One new line word per cycle at most
    task automatic drive_lines(input logic [31:0] v);
        @(negedge clk_i);
        lines_o = v;
    endtask : drive_lines

    // Event requests are one-cycle pulses, released afterwards
    task automatic pulse_events(input logic [3:0] m);
        @(negedge clk_i);
        events_o = m;
        @(negedge clk_i);
        events_o = 4'h0;
    endtask : pulse_events
endmodule : sig_source

`default_nettype wire

//--- verification/test_digital_input_edge_event_capture.sv
// Self-checking bench for the capture block, with a queue-based model.
// Assumes the partner model drives lines and events; bench drives the read port.
`timescale 1ns/1ns
`default_nettype none

module test_digital_input_edge_event_capture;
    logic                       clk;
    logic                       rst_n;
    logic                       rd;
    logic                       pop;
    logic                       rvalid;
    logic                       fvalid;
    dig_capture_pkg::reg_addr_t addr;
    dig_capture_pkg::word_t     rdata;
    dig_capture_pkg::word_t     fdata;
    logic [31:0]                lines;
    logic [3:0]                 evts;
    logic [31:0]                lv, rise, fall, ev, got;
    logic [31:0]                q[$];
    logic [7:0]                 offs[9] = '{8'hd0, 8'he0, 8'he2, 8'he4, 8'he6,
                                            8'he8, 8'hfc, 8'hfe, 8'h10};
    int                         failures;
    int                         tests_run;

    sig_source src_u (.clk_i(clk), .lines_o(lines), .events_o(evts));

    dig_edge_capture dut_u (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .INPUT_LINES_I(lines),
        .EVENT_EXT_I(evts[0]), .EVENT_FIELDBUS_I(evts[1]),
        .EVENT_CAN2_I(evts[2]), .EVENT_CAN1_I(evts[3]),
        .RD_I(rd), .ADDR_I(addr), .RDATA_O(rdata), .RVALID_O(rvalid),
        .EDGE_FIFO_POP_I(pop), .EDGE_FIFO_VALID_O(fvalid),
        .EDGE_FIFO_DATA_O(fdata)
    );

    // Clock at 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One read; answer must appear within a few cycles
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            failures++;
            conclude();
        end else begin
            chk(rdata, e);
        end
    endtask : rdc

    // Drive a word and update the reference flags and queue
    task automatic apply(input logic [31:0] v);
        src_u.drive_lines(v);
        if (v != lv && q.size() < 511) q.push_back(v);
        rise = rise | (~lv & v);
        fall = fall | (lv & ~v);
        lv = v;
    endtask : apply

    // Pop every stored entry; spacing leaves room for the registered head
    task automatic drain();
        for (int n = 0; n < 600 && q.size() > 0; n++) begin
            chk({31'h0, fvalid}, 32'h1);
            chk(fdata, q.pop_front());
            @(negedge clk);
            pop = 1'b1;
            @(negedge clk);
            pop = 1'b0;
            @(negedge clk);
        end
        chk({31'h0, fvalid}, 32'h0);
    endtask : drain

    initial begin
        rd = 1'b0;
        pop = 1'b0;
        addr = 8'h00;
        rst_n = 1'b0;
        lv = 32'h0;
        rise = 32'h0;
        fall = 32'h0;
        ev = 32'h0;
        failures = 0;
        tests_run = 0;
        void'($urandom(32'hf1d7));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        // Every location and an unmapped one read zero after reset
        foreach (offs[i]) rdc(offs[i], 32'h0);
        $display("test reset done");

        for (int i = 0; i < 20; i++) apply($urandom());
        repeat (5) @(negedge clk);
        rdc(8'hd0, lv);
        rdc(8'he4, rise);
        rdc(8'he6, fall);
        rdc(8'he4, rise);
        rdc(8'he0, rise);
        rise = 32'h0;
        rdc(8'he4, rise);
        rdc(8'he2, fall);
        fall = 32'h0;
        rdc(8'he6, fall);
        rdc(8'he8, q.size());
        drain();
        $display("test edges done");

        // One source at a time, so each bit position is pinned down
        for (int i = 0; i < 4; i++) begin
            src_u.pulse_events(4'h1 << i);
            ev = 32'h1 << i;
            repeat (3) @(negedge clk);
            rdc(8'hfe, ev);
            rdc(8'hfc, ev);
        end
        // Event and clearing read in one cycle: the new flag survives
        fork
            src_u.pulse_events(4'h1);
            rdc(8'hfc, 32'h0);
        join
        rdc(8'hfe, 32'h1);
        rdc(8'hfc, 32'h1);
        rdc(8'hfe, 32'h0);
        $display("test events done");

        // Toggle every cycle until the FIFO must refuse
        for (int i = 0; i < 600; i++) apply(lv ^ 32'h1);
        repeat (5) @(negedge clk);
        rdc(8'he8, {15'h0, 1'b1, 7'h0, 9'h1ff});
        rdc(8'he0, rise);
        rdc(8'he2, fall);
        drain();
        rdc(8'he8, 32'h0);
        $display("test overflow done");
        conclude();
    end
endmodule : test_digital_input_edge_event_capture

`default_nettype wire
